/* fetch_accel.sv */
// Instruction fetch accelerator: lookahead queue plus fully associative target store.
// Assumes the Flash answers each read with a one-cycle valid pulse, in order, one read
// outstanding; the core holds its request until it sees valid. Data path is separate.
// How it works
// - Sits between core instruction port and burst Flash on the fetch path.
// - Queue holds up to eight words ahead of the sequential fetch point.
// - Target store has fifteen general entries keyed by branch target.
// - Queue issues Flash reads whenever it has room, also during core idle cycles.
// - Each Flash read moves one 32-bit word; clock stays within 96 MHz.
// - Non-sequential fetch flushes the queue after a store lookup.
// - Each entry keeps a target address and its first eight instructions.
// - Target is compared with all entries at once.
// - On hit store serves words; queue refills from target plus eight words.
// - On miss core waits until Flash delivers the target word.
// - Sixteenth entry is reserved for the interrupt vector-read fetch.
// - Literal data reads never touch the queue.
// - Data port is not routed through this block at all.
`timescale 1ns/100ps
module fetch_accel
  import fetch_accel_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire fetch_req_t        i_fetch,
  input  wire logic              i_literal,      // Request is a literal load
  output fetch_rsp_t             o_rsp,
  output logic                   o_flash_req,
  output logic [ADDR_W-1:0]      o_flash_addr,
  input  wire logic              i_flash_valid,
  input  wire logic [WORD_W-1:0] i_flash_data
);

  // Clock sanity: one word per cycle never exceeds the permitted fetch rate
  localparam bit CLK_OK = (CLK_MHZ <= MAX_FETCH_MHZ);

  // Queue state
  logic [WORD_W-1:0] q_mem_q [QUEUE_DEPTH];
  logic [WORD_W-1:0] q_mem_d [QUEUE_DEPTH];
  logic [QPTR_W-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [QPTR_W:0]   cnt_q, cnt_d;
  logic [ADDR_W-1:0] head_q, head_d;     // Address of the oldest queued word
  logic [ADDR_W-1:0] fadr_q, fadr_d;     // Next Flash read address
  flash_state_t      fst_q, fst_d;
  logic              drop_q, drop_d;     // Discard the reply in flight after a flush
  logic              fill_q, fill_d;     // Capturing a new target line
  logic [ENT_W-1:0]  fent_q, fent_d;
  logic [QPTR_W:0]   fcnt_q, fcnt_d;
  logic [ADDR_W-1:0] nseq_q, nseq_d;     // Next expected sequential address
  // Branch hit streaming
  logic              hit_act_q, hit_act_d;
  logic [ENT_W-1:0]  hent_q, hent_d;
  logic [QPTR_W:0]   hidx_q, hidx_d;
  // Target store
  logic [ADDR_W-1:0] tag_q [ALL_ENTRIES];
  logic [ADDR_W-1:0] tag_d [ALL_ENTRIES];
  logic [WORD_W-1:0] line_q [ALL_ENTRIES][LINE_WORDS];
  logic [WORD_W-1:0] line_d [ALL_ENTRIES][LINE_WORDS];
  logic [ALL_ENTRIES-1:0] vld_q, vld_d;
  logic [ENT_W-1:0]  age_q [GEN_ENTRIES];   // 0 = most recent
  logic [ENT_W-1:0]  age_d [GEN_ENTRIES];
  fetch_rsp_t        rsp_d;
  logic              freq_d;
  logic [ADDR_W-1:0] faddr_d;

  // Parallel compare over all entries
  logic [ALL_ENTRIES-1:0] match;
  genvar g;
  generate
    for (g = 0; g < ALL_ENTRIES; g++)
    begin : g_cmp
      assign match[g] = vld_q[g] && (tag_q[g] == i_fetch.addr);
    end
  endgenerate

  // First set bit of a vector
  function automatic logic [ENT_W-1:0] first_one(input logic [ALL_ENTRIES-1:0] v);
    first_one = '0;
    for (int i = ALL_ENTRIES - 1; i >= 0; i--)
    begin
      if (v[i]) first_one = ENT_W'(i);
    end
  endfunction : first_one

  // Oldest general entry; invalid ones are taken first
  function automatic logic [ENT_W-1:0] victim(input logic [ALL_ENTRIES-1:0] v,
                                               input logic [ENT_W-1:0] a [GEN_ENTRIES]);
    logic [ENT_W-1:0] best;
    logic [ENT_W-1:0] best_age;
    logic             found;
    best = '0;
    best_age = '0;
    found = 1'b0;
    for (int i = 0; i < GEN_ENTRIES; i++)
    begin
      if (!found && !v[i])
      begin
        best = ENT_W'(i);
        found = 1'b1;
      end
      else if (!found && a[i] >= best_age)
      begin
        best = ENT_W'(i);
        best_age = a[i];
      end
    end
    victim = best;
  endfunction : victim

  logic [ENT_W-1:0] hit_ent;
  logic             seq_hit, any_hit, q_has;
  assign hit_ent = i_fetch.irq_vec ? ENT_W'(IRQ_ENTRY) : first_one(match & 16'h7FFF);
  assign any_hit = i_fetch.irq_vec ? match[IRQ_ENTRY] : |(match & 16'h7FFF);
  assign q_has   = (cnt_q != '0) && (head_q == i_fetch.addr);
  assign seq_hit = (i_fetch.addr == nseq_q);

  // A request still held while its answer stands is the finished one, not a new branch
  logic take, hit_go, hit_new, miss_go;
  assign take    = i_fetch.req && !i_literal && !o_rsp.valid;
  assign hit_go  = hit_act_q && seq_hit;                       // Stream goes on only in sequence
  assign hit_new = !seq_hit && !q_has && any_hit;
  assign miss_go = take && !hit_new && !q_has && !seq_hit && !(fadr_q == i_fetch.addr && cnt_q == '0);

  // Next-state for queue, Flash port, target store and core answer
  always_comb
  begin
    q_mem_d = q_mem_q;  rd_d = rd_q;  wr_d = wr_q;  cnt_d = cnt_q;
    head_d = head_q;  fadr_d = fadr_q;  fst_d = fst_q;  drop_d = drop_q;
    fill_d = fill_q;  fent_d = fent_q;  fcnt_d = fcnt_q;  nseq_d = nseq_q;
    hit_act_d = hit_act_q;  hent_d = hent_q;  hidx_d = hidx_q;
    tag_d = tag_q;  line_d = line_q;  vld_d = vld_q;  age_d = age_q;
    rsp_d = '{valid: 1'b0, instr: WORD_RST};
    freq_d = 1'b0;
    faddr_d = fadr_q;

    // Flash reply enters the queue unless it belongs to a flushed stream
    if (fst_q == FL_WAIT && i_flash_valid)
    begin
      fst_d = FL_IDLE;
      if (drop_q)
        drop_d = 1'b0;
      else
      begin
        q_mem_d[wr_q] = i_flash_data;
        wr_d = wr_q + 1'b1;
        cnt_d = cnt_d + 1'b1;
        if (fill_q)
        begin
          line_d[fent_q][fcnt_q[QPTR_W-1:0]] = i_flash_data;
          fcnt_d = fcnt_q + 1'b1;
          if (fcnt_q == (QPTR_W+1)'(LINE_WORDS - 1))
          begin
            fill_d = 1'b0;
            vld_d[fent_q] = 1'b1;
          end
        end
      end
    end

    // Core fetch; literal loads bypass the queue entirely
    if (take)
    begin
      if (hit_go || hit_new)
      begin
        // Served from the target store
        if (!hit_go)
        begin
          hent_d = hit_ent;
          hidx_d = '0;
          hit_act_d = 1'b1;
          // Restart Flash past the stored line
          rd_d = '0;  wr_d = '0;  cnt_d = '0;
          drop_d = (fst_q == FL_WAIT) && !i_flash_valid;
          fill_d = 1'b0;
          fadr_d = i_fetch.addr + ADDR_W'(LINE_WORDS * 4);
          head_d = fadr_d;
          if (hit_ent != ENT_W'(IRQ_ENTRY))
            for (int i = 0; i < GEN_ENTRIES; i++)
              if (age_q[i] < age_q[hit_ent]) age_d[i] = age_q[i] + 1'b1;
          if (hit_ent != ENT_W'(IRQ_ENTRY)) age_d[hit_ent] = '0;
        end
        rsp_d.valid = 1'b1;
        rsp_d.instr = line_q[hit_go ? hent_q : hit_ent][hit_go ? hidx_q[QPTR_W-1:0] : '0];
        hidx_d = (hit_go ? hidx_q : '0) + 1'b1;
        if (hidx_d == (QPTR_W+1)'(LINE_WORDS)) hit_act_d = 1'b0;
        nseq_d = i_fetch.addr + WORD_STEP;
      end
      else if (q_has)
      begin
        // Sequential word ready in the queue
        rsp_d.valid = 1'b1;
        rsp_d.instr = q_mem_q[rd_q];
        hit_act_d = 1'b0;
        rd_d = rd_q + 1'b1;
        cnt_d = cnt_d - 1'b1;
        head_d = head_q + WORD_STEP;
        nseq_d = i_fetch.addr + WORD_STEP;
      end
      else if (!seq_hit && !(fadr_q == i_fetch.addr && cnt_q == '0))
      begin
        // Miss: flush, refetch from target, claim an entry; core stalls
        rd_d = '0;  wr_d = '0;  cnt_d = '0;
        hit_act_d = 1'b0;                    // A branch away ends any store stream
        drop_d = (fst_q == FL_WAIT) && !i_flash_valid;
        fadr_d = i_fetch.addr;
        head_d = i_fetch.addr;
        nseq_d = i_fetch.addr;
        fill_d = 1'b1;
        fcnt_d = '0;
        fent_d = i_fetch.irq_vec ? ENT_W'(IRQ_ENTRY) : victim(vld_q, age_q);
        vld_d[fent_d] = 1'b0;
        tag_d[fent_d] = i_fetch.addr;
        if (!i_fetch.irq_vec)
        begin
          for (int i = 0; i < GEN_ENTRIES; i++)
            if (age_q[i] < age_q[fent_d]) age_d[i] = age_q[i] + 1'b1;
          age_d[fent_d] = '0;
        end
      end
    end

    // Prefetch whenever room remains, even while the core is idle
    if (fst_d == FL_IDLE && cnt_d < (QPTR_W+1)'(QUEUE_DEPTH))
    begin
      freq_d = 1'b1;
      faddr_d = fadr_d;
      fadr_d = fadr_d + WORD_STEP;
      fst_d = FL_WAIT;
    end
  end

  // Registers; reset leaves every entry invalid
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < QUEUE_DEPTH; i++) q_mem_q[i] <= WORD_RST;
      rd_q <= '0;  wr_q <= '0;  cnt_q <= '0;
      head_q <= ADDR_RST;  fadr_q <= ADDR_RST;  nseq_q <= ADDR_RST;
      fst_q <= FL_IDLE;  drop_q <= 1'b0;  fill_q <= 1'b0;
      fent_q <= '0;  fcnt_q <= '0;
      hit_act_q <= 1'b0;  hent_q <= '0;  hidx_q <= '0;
      vld_q <= '0;
      for (int e = 0; e < ALL_ENTRIES; e++)
      begin
        tag_q[e] <= ADDR_RST;
        for (int w = 0; w < LINE_WORDS; w++) line_q[e][w] <= WORD_RST;
      end
      for (int i = 0; i < GEN_ENTRIES; i++) age_q[i] <= ENT_W'(i);
      o_rsp <= '0;
      o_flash_req <= 1'b0;
      o_flash_addr <= ADDR_RST;
    end
    else
    begin
      q_mem_q <= q_mem_d;  rd_q <= rd_d;  wr_q <= wr_d;  cnt_q <= cnt_d;
      head_q <= head_d;  fadr_q <= fadr_d;  nseq_q <= nseq_d;
      fst_q <= fst_d;  drop_q <= drop_d;  fill_q <= fill_d;
      fent_q <= fent_d;  fcnt_q <= fcnt_d;
      hit_act_q <= hit_act_d;  hent_q <= hent_d;  hidx_q <= hidx_d;
      vld_q <= vld_d;  tag_q <= tag_d;  line_q <= line_d;  age_q <= age_d;
      o_rsp <= rsp_d;
      o_flash_req <= freq_d;
      o_flash_addr <= faddr_d;
    end
  end

  // Checks
  property p_depth;
    @(posedge i_clk) disable iff (!i_rst_n) cnt_q <= (QPTR_W+1)'(QUEUE_DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("queue over depth");

  property p_one_out;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_flash_req |=> !o_flash_req until_with (fst_q == FL_WAIT && i_flash_valid);
  endproperty
  a_one_out: assert property (p_one_out) else $error("second Flash read while one pending");

  property p_literal_keeps;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_fetch.req && i_literal && !(fst_q == FL_WAIT && i_flash_valid)) |=> $stable(cnt_q);
  endproperty
  a_literal_keeps: assert property (p_literal_keeps) else $error("literal disturbed queue");

  property p_irq_entry_only;
    @(posedge i_clk) disable iff (!i_rst_n)
      miss_go |=> ((fent_q == ENT_W'(IRQ_ENTRY)) == $past(i_fetch.irq_vec));
  endproperty
  a_irq_entry_only: assert property (p_irq_entry_only) else $error("interrupt entry claimed wrongly");

  property p_flush_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_fetch.req && !i_literal && !o_rsp.valid && !hit_act_q && !q_has && !any_hit && !seq_hit
       && fst_q == FL_IDLE && !(fadr_q == i_fetch.addr && cnt_q == '0))
      |=> (o_flash_req && o_flash_addr == $past(i_fetch.addr));
  endproperty
  a_flush_read: assert property (p_flush_read) else $error("miss did not refetch target");

  property p_hit_serves;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_fetch.req && !i_literal && !o_rsp.valid && !hit_act_q && !q_has && any_hit
       && i_fetch.addr != nseq_q) |=> o_rsp.valid;
  endproperty
  a_hit_serves: assert property (p_hit_serves) else $error("hit not answered next cycle");

  c_hit:  cover property (@(posedge i_clk) disable iff (!i_rst_n) hit_act_q && !hit_act_d);
  c_fill: cover property (@(posedge i_clk) disable iff (!i_rst_n) fill_q && !fill_d);
  c_full: cover property (@(posedge i_clk) disable iff (!i_rst_n) cnt_q == (QPTR_W+1)'(QUEUE_DEPTH));

  initial
  begin
    if (!CLK_OK) $error("clock above fetch limit");
  end

endmodule : fetch_accel

/* fetch_accel_pkg.sv */
// Package for the instruction fetch accelerator: sizes, reset values and carrier types.
// Assumes one 10 MHz clock domain shared by core fetch port and burst Flash port.
package fetch_accel_pkg;

  localparam int unsigned QUEUE_DEPTH   = 8;     // Instructions held ahead
  localparam int unsigned QPTR_W        = 3;
  localparam int unsigned GEN_ENTRIES   = 15;    // General target entries
  localparam int unsigned ALL_ENTRIES   = 16;    // Plus the interrupt entry
  localparam int unsigned ENT_W         = 4;
  localparam int unsigned IRQ_ENTRY     = 15;    // Index of the interrupt entry
  localparam int unsigned LINE_WORDS    = 8;     // Instructions kept per entry
  localparam int unsigned WORD_W        = 32;    // One Flash read moves one word
  localparam int unsigned ADDR_W        = 32;
  localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RST  = 32'h0000_0000;
  localparam int unsigned MAX_FETCH_MHZ = 96;
  localparam int unsigned CLK_MHZ       = 10;

  // Fetch request from the core
  typedef struct packed {
    logic              req;
    logic              irq_vec;    // Fetch of the vector-read instruction
    logic [ADDR_W-1:0] addr;
  } fetch_req_t;

  // Answer to the core
  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] instr;
  } fetch_rsp_t;

  typedef enum logic [1:0] { FL_IDLE, FL_WAIT } flash_state_t;

endpackage : fetch_accel_pkg

/* flash_model.sv */
// Burst Flash model for the fetch accelerator: one word per read, after 1 to 4 cycles.
// Assumes a one-cycle read pulse from the block and only one read outstanding.
`timescale 1ns/100ps
module flash_model
  import fetch_accel_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_req,
  input  wire logic [ADDR_W-1:0] i_addr,
  output logic                   o_valid,
  output logic [WORD_W-1:0]      o_data
);
  logic [ADDR_W-1:0] addr_q;
  int                wait_q;

  // Random wait gives prompt and slow replies; idle data toggles so a stale word never matches
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_valid <= 1'b0;
      o_data  <= WORD_RST;
      wait_q  <= -1;
    end
    else
    begin
      o_valid <= 1'b0;
      o_data  <= ~o_data;
      if (i_req)
      begin
        addr_q <= i_addr;
        wait_q <= $urandom_range(0, 3);
      end
      else if (wait_q == 0)
      begin
        o_valid <= 1'b1;                              // One 32-bit word per read
        o_data  <= {addr_q[15:0], ~addr_q[15:0]};
        wait_q  <= -1;
      end
      else if (wait_q > 0)
        wait_q <= wait_q - 1;
    end
  end
endmodule : flash_model

/* test_fetch_accel.sv */
// Self-checking bench for the fetch accelerator: core driver, Flash model, checks.
// Assumes the core holds each request until the one-cycle answer pulse.
`timescale 1ns/100ps
module test_fetch_accel
  import fetch_accel_pkg::*;
();
  logic              i_clk      = 1'b0;
  logic              i_rst_n    = 1'b0;
  fetch_req_t        i_fetch    = '0;
  logic              i_literal  = 1'b0;
  fetch_rsp_t        o_rsp;
  logic              flash_req;
  logic              flash_valid;
  logic [ADDR_W-1:0] flash_addr;
  logic [WORD_W-1:0] flash_data;
  logic [ADDR_W-1:0] tgt [16];
  int                num_errors = 0;
  int                n_compared = 0;
  int                lat;
  int                cycles     = 0;

  fetch_accel u_dut (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_fetch      (i_fetch),
    .i_literal    (i_literal),
    .o_rsp        (o_rsp),
    .o_flash_req  (flash_req),
    .o_flash_addr (flash_addr),
    .i_flash_valid(flash_valid),
    .i_flash_data (flash_data)
  );

  flash_model u_flash (
    .i_clk  (i_clk),
    .i_rst_n(i_rst_n),
    .i_req  (flash_req),
    .i_addr (flash_addr),
    .o_valid(flash_valid),
    .o_data (flash_data)
  );

  always #50 i_clk = ~i_clk;

  // Word stored at each address: distinct per address
  function automatic logic [WORD_W-1:0] exp_word(input logic [ADDR_W-1:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : exp_word

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask : check

  // Holds the request until the answer pulse, sampled at the falling edge
  task automatic fetch(input logic [ADDR_W-1:0] a, input logic irq);
    begin
      i_fetch <= '{req: 1'b1, irq_vec: irq, addr: a};
      lat = 0;
      do
      begin
        @(negedge i_clk);
        lat++;
      end while (o_rsp.valid !== 1'b1 && lat < 200);
      check("valid", 32'h1, o_rsp.valid);
      check("instr", exp_word(a), o_rsp.instr);
      @(posedge i_clk);
    end
  endtask : fetch

  task automatic run(input logic [ADDR_W-1:0] a, input int n);
    for (int i = 0; i < n; i++)
      fetch(a + WORD_STEP * i, 1'b0);
  endtask : run

  task automatic close_out();
    begin
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask : close_out

  // Cuts a hang short; the whole run needs far fewer cycles
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  initial
  begin
    void'($urandom(48706));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    run(ADDR_RST, 12);
    $display("test sequential done");
    // Miss stalls, then the same target hits the store
    tgt[0] = ADDR_W'($urandom_range(64, 1023)) << 2;
    fetch(tgt[0], 1'b0);
    check("miss_wait", 32'h1, lat > 2);
    run(tgt[0] + WORD_STEP, 7);
    fetch(tgt[0], 1'b0);
    check("hit_fast", 32'h1, lat <= 2);
    run(tgt[0] + WORD_STEP, 10);
    $display("test branch done");
    // Literal load far away must leave the filled queue intact
    i_fetch.req <= 1'b0;
    repeat (48) @(posedge i_clk);
    i_fetch   <= '{req: 1'b1, irq_vec: 1'b0, addr: 32'h0000_F000};
    i_literal <= 1'b1;
    @(posedge i_clk);
    i_literal <= 1'b0;
    fetch(tgt[0] + 32'h0000_002C, 1'b0);
    check("literal_keep", 32'h1, lat <= 2);
    $display("test literal done");
    // Vector-read fetch served from its own entry on the second visit
    fetch(32'h0000_0018, 1'b1);
    run(32'h0000_001C, 7);
    fetch(tgt[0], 1'b0);
    fetch(32'h0000_0018, 1'b1);
    check("irq_fast", 32'h1, lat <= 2);
    $display("test vector done");
    // Sixteen new targets: oldest falls out, last fifteen stay
    for (int k = 0; k < 16; k++)
    begin
      tgt[k] = ADDR_W'($urandom_range(16 * k + 300, 16 * k + 310)) << 6;
      fetch(tgt[k], 1'b0);
      run(tgt[k] + WORD_STEP, 7);
    end
    for (int k = 1; k < 16; k++)
    begin
      fetch(tgt[k], 1'b0);
      check("lru_hit", 32'h1, lat <= 2);
    end
    // Idle 20 cycles; the queue is still filling, so this miss meets a busy Flash port
    i_fetch.req <= 1'b0;
    repeat (20) @(posedge i_clk);
    fetch(tgt[0], 1'b0);
    check("lru_evict", 32'h1, lat > 2);
    i_fetch.req <= 1'b0;
    $display("test replacement done");
    close_out();
  end
endmodule : test_fetch_accel
